// ==== pkg/dms_consts.svh ====
// Constants of the display memory sequencer: field layout, windows, depths
`ifndef DMS_CONSTS_SVH
`define DMS_CONSTS_SVH

// Memory word address and data layout
`define DMS_WA        20
`define DMS_DW        32
`define DMS_LANES     4
`define DMS_ROW_MSB   19
`define DMS_ROW_LSB   10
`define DMS_COL_MSB   9

// Host address windows, inclusive bounds
`define DMS_WIN0_BASE 24'h0a0000
`define DMS_WIN0_LAST 24'h0bffff
`define DMS_WIN1_BASE 24'h0a0000
`define DMS_WIN1_LAST 24'h0affff
`define DMS_WIN2_BASE 24'h0b0000
`define DMS_WIN2_LAST 24'h0b7fff
`define DMS_LIN_BASE  24'h400000
`define DMS_LIN_LAST  24'h7fffff

// Buffering and refresh
`define DMS_FIFO_DEPTH 16
`define DMS_LOW_MARK   8
`define DMS_REF_W      3

`endif

// ==== pkg/dms_pkg.sv ====
// Types shared by the display memory sequencer modules
`default_nettype none
package dms_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ROW  = 3'h1,
    S_COL  = 3'h2,
    S_CASH = 3'h3,
    S_PRE  = 3'h4,
    S_RFC  = 3'h5,
    S_RFR  = 3'h6,
    S_RFE  = 3'h7
  } seq_state_t;

  typedef enum logic [2:0] {
    G_NONE = 3'h0,
    G_REF  = 3'h1,
    G_VID  = 3'h2,
    G_HRD  = 3'h3,
    G_WBUF = 3'h4,
    G_BLT  = 3'h5
  } grant_t;

  typedef enum logic [1:0] {
    AM_PLANAR  = 2'h0,
    AM_ODDEVEN = 2'h1,
    AM_CHAIN4  = 2'h2,
    AM_PACKED  = 2'h3
  } amode_t;
endpackage
`default_nettype wire

// ==== hw/stream_fifo.sv ====
// Synchronous FIFO with registered output stage and registered ready
`timescale 1ns/1ns
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int LW    = $clog2(DEPTH) + 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready,
  // Words held in the array
  output logic [LW-1:0]         level
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("stream_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [LW-1:0]               cnt;
    logic                        in_ready;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } fifo_t;

  fifo_t q;
  fifo_t next_q;
  logic  push;
  logic  pop;

  always_comb begin
    next_q = q;
    push   = in_valid & q.in_ready;
    pop    = (q.cnt != '0) & (~q.out_valid | out_ready);
    if (q.out_valid & out_ready) begin
      next_q.out_valid = 1'b0;
    end
    if (pop) begin
      next_q.out_data  = q.mem[q.rp];
      next_q.out_valid = 1'b1;
      next_q.rp        = q.rp + 1'b1;
    end
    if (push) begin
      next_q.mem[q.wp] = in_data;
      next_q.wp        = q.wp + 1'b1;
    end
    next_q.cnt      = q.cnt + LW'(push) - LW'(pop);
    next_q.in_ready = next_q.cnt != LW'(DEPTH);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q          <= '0;
      q.in_ready <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign in_ready  = q.in_ready;
  assign out_valid = q.out_valid;
  assign out_data  = q.out_data;
  assign level     = q.cnt;
endmodule
`default_nettype wire

// ==== hw/addr_map.sv ====
// Host address window decode and addressing-mode transform to memory words
`timescale 1ns/1ns
`default_nettype none
`include "dms_consts.svh"
module addr_map (
  // Host side
  input  wire logic [23:0]            host_addr,
  input  wire logic [1:0]             addr_mode,
  input  wire logic [1:0]             map_sel,
  input  wire logic [`DMS_LANES-1:0]  plane_en,
  // Memory side
  output logic [`DMS_WA-1:0]          word_addr,
  output logic [`DMS_LANES-1:0]       lanes,
  output logic                        hit
);
  logic [23:0] base;
  logic [23:0] last;
  logic [23:0] off;

  always_comb begin
    unique case (map_sel)
      2'h0: begin
        base = `DMS_WIN0_BASE;
        last = `DMS_WIN0_LAST;
      end
      2'h1: begin
        base = `DMS_WIN1_BASE;
        last = `DMS_WIN1_LAST;
      end
      2'h2: begin
        base = `DMS_WIN2_BASE;
        last = `DMS_WIN2_LAST;
      end
      2'h3: begin
        base = `DMS_LIN_BASE;
        last = `DMS_LIN_LAST;
      end
    endcase
    hit = (host_addr >= base) && (host_addr <= last);
    off = host_addr - base;
    unique case (dms_pkg::amode_t'(addr_mode))
      dms_pkg::AM_PLANAR: begin
        word_addr = off[`DMS_WA-1:0];
        lanes     = 4'hf;
      end
      dms_pkg::AM_ODDEVEN: begin
        word_addr = off[`DMS_WA:1];
        lanes     = off[0] ? 4'ha : 4'h5;
      end
      dms_pkg::AM_CHAIN4: begin
        word_addr = off[`DMS_WA+1:2];
        lanes     = 4'h1 << off[1:0];
      end
      dms_pkg::AM_PACKED: begin
        word_addr = off[`DMS_WA+1:2];
        lanes     = 4'hf;
      end
    endcase
    // Legacy windows mask the mode's lanes with the chosen planes; the linear window ignores them
    if (map_sel != 2'h3) begin
      lanes = lanes & plane_en;
    end
  end
endmodule
`default_nettype wire

// ==== hw/display_memory_sequencer.sv ====
// Display memory sequencer: write buffer, arbiter, DRAM strobes, video FIFO
`timescale 1ns/1ns
`default_nettype none
`include "dms_consts.svh"
module display_memory_sequencer #(
  parameter int FIFO_DEPTH = `DMS_FIFO_DEPTH,
  parameter int LOW_MARK   = `DMS_LOW_MARK
) (
  // Memory clock and reset
  input  wire logic                   SYS_CLK,
  input  wire logic                   RST_B,
  // Configuration levels
  input  wire logic [1:0]             ADDR_MODE,
  input  wire logic [1:0]             MAP_SEL,
  input  wire logic [`DMS_REF_W-1:0]  REFRESH_COUNT,
  input  wire logic                   DUAL_CAS,
  // Host memory access
  input  wire logic [23:0]            HOST_ADDR,
  input  wire logic [`DMS_LANES-1:0]  HOST_PLANE_EN,
  input  wire logic                   HOST_WR_VALID,
  input  wire logic [`DMS_DW-1:0]     HOST_WDATA,
  output logic                        HOST_WR_READY,
  input  wire logic                   HOST_RD_REQ,
  output logic                        HOST_RD_ACK,
  // Block transfer engine access
  input  wire logic                   BLT_REQ,
  input  wire logic                   BLT_WE,
  input  wire logic [`DMS_WA-1:0]     BLT_ADDR,
  input  wire logic [`DMS_DW-1:0]     BLT_WDATA,
  output logic                        BLT_ACK,
  // Read data for host and block transfer engine
  output logic [`DMS_DW-1:0]          RD_DATA,
  // Display timing unit
  input  wire logic                   HBLANK,
  input  wire logic                   VBLANK,
  input  wire logic                   DISP_FETCH_REQ,
  input  wire logic [`DMS_WA-1:0]     DISP_FETCH_ADDR,
  output logic                        DISP_FETCH_ACK,
  // Attribute stage
  output logic                        VID_VALID,
  output logic [`DMS_DW-1:0]          VID_DATA,
  input  wire logic                   VID_READY,
  // Display DRAM
  output logic [9:0]                  MEM_ADDR_BUS,
  output logic                        RAS_B,
  output logic                        CAS_B,
  output logic                        OE_B,
  output logic [`DMS_LANES-1:0]       WE_B,
  input  wire logic [`DMS_DW-1:0]     MD_IN,
  output logic [`DMS_DW-1:0]          MD_OUT,
  output logic                        MD_OE
);
  localparam int LW  = $clog2(FIFO_DEPTH) + 1;
  localparam int WBW = `DMS_WA + `DMS_LANES + `DMS_DW;

  generate
    if (LOW_MARK < 1 || LOW_MARK > FIFO_DEPTH - 3) begin : g_chk
      $error("LOW_MARK must lie between 1 and FIFO_DEPTH-3");
    end
  endgenerate

  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  typedef struct packed {
    dms_pkg::seq_state_t       st;
    dms_pkg::grant_t           src;
    logic [`DMS_WA-1:0]        addr;
    logic [`DMS_DW-1:0]        data;
    logic [`DMS_LANES-1:0]     lanes;
    logic                      wr;
    logic [`DMS_REF_W-1:0]     owed;
    logic                      hb;
    logic [9:0]                ma;
    logic                      ras_b;
    logic                      cas_b;
    logic                      oe_b;
    logic [`DMS_LANES-1:0]     we_b;
    logic [`DMS_DW-1:0]        md_out;
    logic                      md_oe;
    logic [`DMS_DW-1:0]        rd_data;
    logic                      hrd_ack;
    logic                      blt_ack;
    logic                      fetch_ack;
  } seq_t;

  seq_t q;
  seq_t next_q;

  logic [`DMS_WA-1:0]    hmap_addr;
  logic [`DMS_LANES-1:0] hmap_lanes;
  logic                  hmap_hit;
  logic                  wb_valid;
  logic [WBW-1:0]        wb_data;
  logic                  wb_pop;
  logic                  vpush;
  logic [LW-1:0]         vlevel;
  logic [LW-1:0]         wlevel;
  logic                  active;
  logic                  room;
  logic                  urgent;
  logic                  more;

  //----------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------
  // Returns {CAS pin, WE pins}; strobe roles swap in dual-CAS mode for reads and refresh, writes are unchanged
  function automatic logic [4:0] strobes(input logic dual, input logic on,
                                         input logic wr, input logic [3:0] ln);
    if (!on) begin
      strobes = 5'h1f;
    end else if (dual) begin
      strobes = {~wr, wr ? ~ln : 4'h0};
    end else begin
      strobes = {1'b0, wr ? ~ln : 4'hf};
    end
  endfunction

  // Latches an access and drives its row with RAS low
  function automatic seq_t open_row(input seq_t s, input dms_pkg::grant_t g,
                                    input logic [`DMS_WA-1:0] a,
                                    input logic [`DMS_DW-1:0] d,
                                    input logic [3:0] ln, input logic wr);
    open_row       = s;
    open_row.src   = g;
    open_row.addr  = a;
    open_row.data  = d;
    open_row.lanes = ln;
    open_row.wr    = wr;
    open_row.ma    = a[`DMS_ROW_MSB:`DMS_ROW_LSB];
    open_row.ras_b = 1'b0;
    open_row.st    = dms_pkg::S_ROW;
  endfunction

  //----------------------------------------------------------------
  // Host address transform and write buffer
  //----------------------------------------------------------------
  addr_map u_map (
    .host_addr (HOST_ADDR),
    .addr_mode (ADDR_MODE),
    .map_sel   (MAP_SEL),
    .plane_en  (HOST_PLANE_EN),
    .word_addr (hmap_addr),
    .lanes     (hmap_lanes),
    .hit       (hmap_hit)
  );

  // Host side takes writes without waiting on DRAM traffic until the write buffer is full
  stream_fifo #(
    .WIDTH (WBW),
    .DEPTH (FIFO_DEPTH)
  ) u_wbuf (
    .clk       (SYS_CLK),
    .rst_b     (RST_B),
    .in_valid  (HOST_WR_VALID & hmap_hit),
    .in_data   ({hmap_addr, hmap_lanes, HOST_WDATA}),
    .in_ready  (HOST_WR_READY),
    .out_valid (wb_valid),
    .out_data  (wb_data),
    .out_ready (wb_pop),
    .level     (wlevel)
  );

  //----------------------------------------------------------------
  // Video FIFO toward the attribute stage
  //----------------------------------------------------------------
  stream_fifo #(
    .WIDTH (`DMS_DW),
    .DEPTH (FIFO_DEPTH)
  ) u_vfifo (
    .clk       (SYS_CLK),
    .rst_b     (RST_B),
    .in_valid  (vpush),
    .in_data   (MD_IN),
    .in_ready  (),
    .out_valid (VID_VALID),
    .out_data  (VID_DATA),
    .out_ready (VID_READY),
    .level     (vlevel)
  );

  //----------------------------------------------------------------
  // Arbiter and DRAM sequencer
  //----------------------------------------------------------------
  always_comb begin
    next_q           = q;
    next_q.hrd_ack   = 1'b0;
    next_q.blt_ack   = 1'b0;
    next_q.fetch_ack = 1'b0;
    next_q.hb        = HBLANK;
    wb_pop           = 1'b0;
    vpush            = 1'b0;
    active           = ~HBLANK & ~VBLANK;
    // Two slots kept free: one word may be in flight behind the check
    room             = vlevel < LW'(FIFO_DEPTH - 2);
    urgent           = active & DISP_FETCH_REQ & (vlevel < LW'(LOW_MARK));
    more             = DISP_FETCH_REQ & room & (q.owed == '0) &
                       (DISP_FETCH_ADDR[`DMS_ROW_MSB:`DMS_ROW_LSB] ==
                        q.addr[`DMS_ROW_MSB:`DMS_ROW_LSB]);
    unique case (q.st)
      dms_pkg::S_IDLE: begin
        if (q.owed != '0) begin
          next_q.owed  = q.owed - 1'b1;
          next_q.src   = dms_pkg::G_REF;
          {next_q.cas_b, next_q.we_b} = strobes(DUAL_CAS, 1'b1, 1'b0, 4'h0);
          next_q.st    = dms_pkg::S_RFC;
        end else if (urgent) begin
          next_q = open_row(q, dms_pkg::G_VID, DISP_FETCH_ADDR, '0, 4'hf, 1'b0);
        end else if (HOST_RD_REQ & ~q.hrd_ack & ~wb_valid & ~|wlevel) begin
          // Reads wait for buffered writes so they see the newest data
          if (hmap_hit) begin
            next_q = open_row(q, dms_pkg::G_HRD, hmap_addr, '0, hmap_lanes, 1'b0);
          end else begin
            next_q.rd_data = '0;
            next_q.hrd_ack = 1'b1;
          end
        end else if (wb_valid) begin
          wb_pop = 1'b1;
          next_q = open_row(q, dms_pkg::G_WBUF, wb_data[WBW-1:WBW-`DMS_WA],
                            wb_data[`DMS_DW-1:0],
                            wb_data[`DMS_DW+`DMS_LANES-1:`DMS_DW], 1'b1);
        end else if (BLT_REQ & ~q.blt_ack) begin
          next_q = open_row(q, dms_pkg::G_BLT, BLT_ADDR, BLT_WDATA, 4'hf, BLT_WE);
        end else if (DISP_FETCH_REQ & room) begin
          next_q = open_row(q, dms_pkg::G_VID, DISP_FETCH_ADDR, '0, 4'hf, 1'b0);
        end
      end
      dms_pkg::S_ROW: begin
        next_q.ma        = q.addr[`DMS_COL_MSB:0];
        {next_q.cas_b, next_q.we_b} = strobes(DUAL_CAS, 1'b1, q.wr, q.lanes);
        next_q.oe_b      = q.wr;
        next_q.md_out    = q.data;
        next_q.md_oe     = q.wr;
        next_q.fetch_ack = q.src == dms_pkg::G_VID;
        next_q.st        = dms_pkg::S_COL;
      end
      dms_pkg::S_COL: begin
        if (!q.wr) begin
          if (q.src == dms_pkg::G_VID) begin
            vpush = 1'b1;
          end else begin
            next_q.rd_data = MD_IN;
          end
        end
        next_q.hrd_ack = q.src == dms_pkg::G_HRD;
        next_q.blt_ack = q.src == dms_pkg::G_BLT;
        {next_q.cas_b, next_q.we_b} = strobes(DUAL_CAS, 1'b0, 1'b0, 4'h0);
        next_q.oe_b    = 1'b1;
        next_q.md_oe   = 1'b0;
        if (q.src == dms_pkg::G_VID) begin
          next_q.st    = dms_pkg::S_CASH;
        end else begin
          next_q.ras_b = 1'b1;
          next_q.st    = dms_pkg::S_PRE;
        end
      end
      dms_pkg::S_CASH: begin
        // Fast page burst continues while the row holds, room remains and no refresh is owed
        if (more) begin
          next_q.addr      = DISP_FETCH_ADDR;
          next_q.ma        = DISP_FETCH_ADDR[`DMS_COL_MSB:0];
          {next_q.cas_b, next_q.we_b} = strobes(DUAL_CAS, 1'b1, 1'b0, 4'hf);
          next_q.oe_b      = 1'b0;
          next_q.fetch_ack = 1'b1;
          next_q.st        = dms_pkg::S_COL;
        end else begin
          next_q.ras_b     = 1'b1;
          next_q.st        = dms_pkg::S_PRE;
        end
      end
      dms_pkg::S_PRE: begin
        next_q.src = dms_pkg::G_NONE;
        next_q.st  = dms_pkg::S_IDLE;
      end
      dms_pkg::S_RFC: begin
        next_q.ras_b = 1'b0;
        next_q.st    = dms_pkg::S_RFR;
      end
      dms_pkg::S_RFR: begin
        next_q.ras_b = 1'b1;
        {next_q.cas_b, next_q.we_b} = strobes(DUAL_CAS, 1'b0, 1'b0, 4'h0);
        next_q.st    = dms_pkg::S_RFE;
      end
      dms_pkg::S_RFE: begin
        next_q.src = dms_pkg::G_NONE;
        next_q.st  = dms_pkg::S_IDLE;
      end
    endcase
    // A new horizontal blanking period reloads the refresh quota, winning over a decrement
    if (HBLANK & ~q.hb) begin
      next_q.owed = REFRESH_COUNT;
    end
  end

  // All DRAM controls come from this memory-clock register
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      q       <= '0;
      q.ras_b <= 1'b1;
      q.cas_b <= 1'b1;
      q.oe_b  <= 1'b1;
      q.we_b  <= 4'hf;
    end else begin
      q <= next_q;
    end
  end

  //----------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------
  assign MEM_ADDR_BUS   = q.ma;
  assign RAS_B          = q.ras_b;
  assign CAS_B          = q.cas_b;
  assign OE_B           = q.oe_b;
  assign WE_B           = q.we_b;
  assign MD_OUT         = q.md_out;
  assign MD_OE          = q.md_oe;
  assign RD_DATA        = q.rd_data;
  assign HOST_RD_ACK    = q.hrd_ack;
  assign BLT_ACK        = q.blt_ack;
  assign DISP_FETCH_ACK = q.fetch_ack;
endmodule
`default_nettype wire

// ==== sim/dms_chk.sv ====
// Port checker of the display memory sequencer, bound to its top module
`timescale 1ns/1ns
`default_nettype none
`include "dms_consts.svh"
module dms_chk #(
  parameter int FIFO_DEPTH = 16,
  parameter int LOW_MARK   = 8
) (
  // Clock and reset
  input wire logic                  SYS_CLK,
  input wire logic                  RST_B,
  // Mode and handshakes
  input wire logic                  DUAL_CAS,
  input wire logic                  HOST_RD_REQ,
  input wire logic                  HOST_RD_ACK,
  input wire logic                  DISP_FETCH_ACK,
  input wire logic                  VID_VALID,
  input wire logic [`DMS_DW-1:0]    VID_DATA,
  input wire logic                  VID_READY,
  // DRAM strobes
  input wire logic                  RAS_B,
  input wire logic                  CAS_B,
  input wire logic                  OE_B,
  input wire logic [`DMS_LANES-1:0] WE_B,
  input wire logic                  MD_OE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  // Column strobe leads row strobe, then both release
  sequence cbr_lead;  RAS_B && !CAS_B && !DUAL_CAS; endsequence
  sequence cbr_tail;  !RAS_B && !CAS_B ##1 RAS_B && CAS_B; endsequence
  sequence dcbr_lead; RAS_B && WE_B == 4'h0 && DUAL_CAS; endsequence
  sequence dcbr_tail; !RAS_B ##1 RAS_B && WE_B == 4'hf; endsequence

  cbr_norm_a: assert property (cbr_lead |=> cbr_tail)
    else $error("normal refresh strobe order wrong");
  cbr_dual_a: assert property (dcbr_lead |=> dcbr_tail)
    else $error("dual mode refresh strobe order wrong");
  rd_pulse_a: assert property (HOST_RD_ACK |=> !HOST_RD_ACK)
    else $error("read ack longer than one cycle");
  rd_cause_a: assert property ($rose(HOST_RD_ACK) |-> $past(HOST_RD_REQ))
    else $error("read ack without request");
  fetch_pulse_a: assert property (DISP_FETCH_ACK |=> !DISP_FETCH_ACK)
    else $error("fetch ack longer than one cycle");
  vid_hold_a: assert property (VID_VALID && !VID_READY |=> VID_VALID && $stable(VID_DATA))
    else $error("video word dropped while stalled");
  wr_drive_a: assert property (MD_OE |-> !RAS_B && OE_B && !CAS_B &&
    (DUAL_CAS || WE_B != 4'hf))
    else $error("write data driven outside a write strobe");
  rd_strobe_a: assert property (!OE_B |-> !RAS_B && !MD_OE &&
    (DUAL_CAS ? CAS_B : WE_B == 4'hf))
    else $error("read strobes wrong for memory mode");
  ras_bound_a: assert property ($fell(RAS_B) |-> ##[1:60] RAS_B)
    else $error("row strobe held too long");
endmodule

bind display_memory_sequencer dms_chk #(.FIFO_DEPTH(FIFO_DEPTH), .LOW_MARK(LOW_MARK)) chk_u (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .DUAL_CAS(DUAL_CAS), .HOST_RD_REQ(HOST_RD_REQ),
  .HOST_RD_ACK(HOST_RD_ACK), .DISP_FETCH_ACK(DISP_FETCH_ACK), .VID_VALID(VID_VALID),
  .VID_DATA(VID_DATA), .VID_READY(VID_READY), .RAS_B(RAS_B), .CAS_B(CAS_B), .OE_B(OE_B),
  .WE_B(WE_B), .MD_OE(MD_OE));
`default_nettype wire

// ==== sim/dram_model.sv ====
// Behavioural display DRAM bank answering the sequencer strobes
`timescale 1ns/1ns
`default_nettype none
module dram_model (
  // Controller side
  input  wire logic        clk,
  input  wire logic        dual_cas,
  input  wire logic [9:0]  addr,
  input  wire logic        ras_b,
  input  wire logic        cas_b,
  input  wire logic        oe_b,
  input  wire logic [3:0]  we_b,
  input  wire logic [31:0] wdata,
  // Data back to the controller
  output logic      [31:0] rdata
);
  logic [31:0] mem[int];
  logic [9:0]  row   = 10'h0;
  logic        ras_q = 1'b1;
  logic [31:0] last  = 32'h0;
  logic [3:0]  lanes;
  logic        rd_on;
  logic [19:0] word;

  assign word  = {row, addr};
  // Dual mode swaps the column strobe and the write enables for reads; writes decode the same in both modes
  assign lanes = (!ras_b && !cas_b) ? ~we_b : 4'h0;
  assign rd_on = !ras_b && !oe_b && (dual_cas ? (cas_b && we_b == 4'h0) : !cas_b);

  // Released pins show the inverse of the last value, never a stale copy
  always @(negedge clk)
    rdata <= rd_on ? (mem.exists(word) ? mem[word] : 32'h0) : ~last;

  always @(posedge clk) begin
    logic [31:0] cur;
    cur = mem.exists(word) ? mem[word] : 32'h0;
    for (int i = 0; i < 4; i++)
      if (lanes[i]) cur[8*i +: 8] = wdata[8*i +: 8];
    if (lanes != 4'h0) mem[word] = cur;
    if (ras_q && !ras_b) row <= addr;
    ras_q <= ras_b;
    last <= rdata;
  end
endmodule
`default_nettype wire

// ==== sim/display_memory_sequencer_tb_top.sv ====
// Self-checking bench of the display memory sequencer
`timescale 1ns/1ns
`default_nettype none
`include "dms_consts.svh"
module display_memory_sequencer_tb_top;
  typedef struct {
    logic [1:0]  mode;
    logic [1:0]  map;
    logic [3:0]  pl;
    logic [23:0] addr;
    logic [31:0] data;
    logic [31:0] exp;
  } row_t;
  // Mode, window, planes, address, write data, word read back
  row_t rows[7] = '{
    '{2'h0, 2'h0, 4'hf, 24'h0a0010, 32'h11223344, 32'h11223344},
    '{2'h0, 2'h0, 4'h5, 24'h0a0020, 32'haabbccdd, 32'h00bb00dd},
    '{2'h2, 2'h0, 4'hf, 24'h0a0103, 32'h55667788, 32'h55000000},
    '{2'h1, 2'h0, 4'hf, 24'h0a0201, 32'h99aabbcc, 32'h9900bb00},
    '{2'h3, 2'h3, 4'hf, 24'h400800, 32'h01234567, 32'h01234567},
    '{2'h0, 2'h1, 4'hf, 24'h0b0000, 32'h12345678, 32'h00000000},
    '{2'h0, 2'h2, 4'h3, 24'h0b0030, 32'h0acd1234, 32'h00001234}};
  logic [2:0]  counts[3] = '{3'h0, 3'h2, 3'h7};
  logic        sys_clk = 1'b0;
  logic        rst_b, dual_cas, wr_valid, rd_req, blt_req, blt_we, hblank, vblank;
  logic        f_req, vid_ready, wr_ready, rd_ack, blt_ack, f_ack, vid_valid;
  logic        ras_b, cas_b, oe_b, md_oe;
  logic [1:0]  addr_mode, map_sel;
  logic [2:0]  refresh_count;
  logic [3:0]  plane_en, we_b;
  logic [9:0]  ma;
  logic [19:0] blt_addr, f_addr;
  logic [23:0] host_addr;
  logic [31:0] wdata, blt_wdata, rd_data, vid_data, md_in, md_out;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          stalls, cbr_seen;
  logic        ras_q = 1'b1;

  always #50 sys_clk = ~sys_clk;

  display_memory_sequencer dut_u (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .ADDR_MODE(addr_mode), .MAP_SEL(map_sel),
    .REFRESH_COUNT(refresh_count), .DUAL_CAS(dual_cas), .HOST_ADDR(host_addr),
    .HOST_PLANE_EN(plane_en), .HOST_WR_VALID(wr_valid), .HOST_WDATA(wdata),
    .HOST_WR_READY(wr_ready), .HOST_RD_REQ(rd_req), .HOST_RD_ACK(rd_ack),
    .BLT_REQ(blt_req), .BLT_WE(blt_we), .BLT_ADDR(blt_addr), .BLT_WDATA(blt_wdata),
    .BLT_ACK(blt_ack), .RD_DATA(rd_data), .HBLANK(hblank), .VBLANK(vblank),
    .DISP_FETCH_REQ(f_req), .DISP_FETCH_ADDR(f_addr), .DISP_FETCH_ACK(f_ack),
    .VID_VALID(vid_valid), .VID_DATA(vid_data), .VID_READY(vid_ready),
    .MEM_ADDR_BUS(ma), .RAS_B(ras_b), .CAS_B(cas_b), .OE_B(oe_b), .WE_B(we_b),
    .MD_IN(md_in), .MD_OUT(md_out), .MD_OE(md_oe));

  dram_model dram_u (
    .clk(sys_clk), .dual_cas(dual_cas), .addr(ma), .ras_b(ras_b), .cas_b(cas_b),
    .oe_b(oe_b), .we_b(we_b), .wdata(md_out), .rdata(md_in));

  // Counts refresh cycles: row strobe falling while the column strobe is already low
  always @(negedge sys_clk) begin
    if (ras_q && !ras_b && (dual_cas ? we_b === 4'h0 : cas_b === 1'b0))
      cbr_seen++;
    ras_q = ras_b;
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Valid stays up between writes so back-to-back offers need no gap
  task automatic host_write(input logic [23:0] a, input logic [31:0] d);
    int n = 0;
    host_addr = a;
    wdata = d;
    wr_valid = 1'b1;
    while (wr_ready !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    stalls += n;
    tick();
  endtask

  task automatic host_read(input logic [23:0] a, input logic [31:0] e);
    int n = 0;
    host_addr = a;
    rd_req = 1'b1;
    tick();
    while (rd_ack !== 1'b1 && n < 200) begin
      tick();
      n++;
    end
    rd_req = 1'b0;
    chk(32'(rd_ack), 32'h1, "read ack");
    chk(rd_data, e, "read data");
    tick();
  endtask

  task automatic block_transfer_engine(input logic we, input logic [19:0] a, input logic [31:0] d);
    int n = 0;
    blt_we = we;
    blt_addr = a;
    blt_wdata = d;
    blt_req = 1'b1;
    tick();
    while (blt_ack !== 1'b1 && n < 200) begin
      tick();
      n++;
    end
    blt_req = 1'b0;
    chk(32'(blt_ack), 32'h1, "blt ack");
    if (!we) chk(rd_data, d, "blt read");
    tick();
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #2000000;
    miscompares++;
    $display("watchdog expired");
    complete_run();
  end

  initial begin
    int n, acks;
    {rst_b, dual_cas, wr_valid, rd_req, blt_req, blt_we, hblank, vblank} = 8'h0;
    {f_req, vid_ready, addr_mode, map_sel, refresh_count, plane_en} = 13'h0;
    {blt_addr, f_addr, host_addr, wdata, blt_wdata} = 128'h0;
    tick(10);
    chk(32'({ras_b, cas_b, oe_b, we_b, md_oe, wr_ready}), 32'h1fd, "in reset");
    rst_b = 1'b1;
    tick();
    chk(32'(wr_ready), 32'h1, "ready after reset");
    $display("test reset done");
    for (int d = 0; d < 2; d++) begin
      dual_cas = d[0];
      foreach (rows[i]) begin
        addr_mode = rows[i].mode;
        map_sel = rows[i].map;
        plane_en = rows[i].pl;
        chk(32'(wr_ready), 32'h1, "ready idle");
        host_write(rows[i].addr, rows[i].data);
        wr_valid = 1'b0;
        host_read(rows[i].addr, rows[i].exp);
      end
    end
    $display("test table done");
    {addr_mode, map_sel, plane_en, dual_cas, stalls} = {8'h0f, 1'b0, 32'h0};
    for (int k = 0; k < 40; k++) begin
      host_write(24'h0a0400 + 24'(k), 32'h5a000000 + 32'(k));
      if (k == 15) chk(stalls, 32'h0, "stall before full");
    end
    wr_valid = 1'b0;
    chk(32'(stalls > 0), 32'h1, "no stall when full");
    host_read(24'h0a0427, 32'h5a000027);
    $display("test buffer done");
    for (int k = 0; k < 4; k++) host_write(24'h0a0300 + 24'(k), 32'h0f0f0000 + 32'(k));
    wr_valid = 1'b0;
    host_read(24'h0a0303, 32'h0f0f0003);
    f_addr = 20'h00300;
    f_req = 1'b1;
    n = 0;
    acks = 0;
    while (acks < 4 && n < 200) begin
      tick();
      n++;
      if (f_ack === 1'b1) begin
        acks++;
        f_addr = f_addr + 20'h1;
        if (acks == 4) f_req = 1'b0;
      end
    end
    chk(acks, 32'h4, "fetch acks");
    tick(6);
    vid_ready = 1'b1;
    for (int k = 0; k < 4; k++) begin
      n = 0;
      while (vid_valid !== 1'b1 && n < 50) begin
        tick();
        n++;
      end
      chk(vid_data, 32'h0f0f0000 + 32'(k), "video word");
      tick();
    end
    vid_ready = 1'b0;
    $display("test fetch done");
    block_transfer_engine(1'b1, 20'h003f0, 32'h0bad0f00);
    block_transfer_engine(1'b0, 20'h003f0, 32'h0bad0f00);
    host_read(24'h0a03f0, 32'h0bad0f00);
    $display("test blt done");
    for (int d = 0; d < 2; d++) begin
      foreach (counts[j]) begin
        dual_cas = d[0];
        refresh_count = counts[j];
        cbr_seen = 0;
        hblank = 1'b1;
        tick(40);
        hblank = 1'b0;
        tick(4);
        chk(cbr_seen, 32'(counts[j]), "refresh cycles");
      end
    end
    $display("test refresh done");
    rst_b = 1'b0;
    #10;
    chk(32'({ras_b, wr_ready, vid_valid}), 32'h6, "second reset");
    tick();
    rst_b = 1'b1;
    tick();
    $display("test second reset done");
    complete_run();
  end
endmodule
`default_nettype wire
